// ### hdl/quad_port_irq_pkg.sv
package quad_port_irq_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned STATUS_RSV_W = DATA_W - NUM_PORTS;

  ////////////////////////////////////////////////////////////////////////////
  // Address map
  localparam logic [2:0] STATUS_OFFSET = 3'h7;
  localparam int unsigned PORT_SPAN_LSB = 3;
  localparam int unsigned ADDR_HIGH_LSB = 10;
  localparam int unsigned COMPAT_BASE_LSB = 5;
  localparam int unsigned COMPAT_BASE_MSB = 9;
  localparam int unsigned COMPAT_SEL_LSB = 3;
  localparam int unsigned COMPAT_SEL_MSB = 4;
  // Factory table: entry 0 is the first port
  localparam logic [3:0][15:0] FACTORY_BASE = {16'h02e8, 16'h03e8, 16'h02f8, 16'h03f8};
  // Request line routing: ports 1 and 3 on line 4, ports 2 and 4 on line 3
  localparam logic [3:0] LINE4_PORTS = 4'h5;
  localparam logic [3:0] LINE3_PORTS = 4'ha;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DRV_HOLD_NS = 25000;
  localparam int unsigned DRV_HOLD_CYCLES = (DRV_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle tracking
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_READ = 2'h1,
    BUS_WRITE = 2'h2
  } bus_state_e;

endpackage

// ### hdl/pin_sync.sv
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
      stage3_ff <= RST_VAL;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // A bit moves only once the second and third stage agree
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_ff <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_ff[i] == stage3_ff[i]) begin
          level_ff[i] <= stage3_ff[i];
        end
      end
    end
  end

  assign level_out = level_ff;

endmodule

// ### hdl/quad_port_irq_status_decode.sv
module quad_port_irq_status_decode #(
  parameter int unsigned DRV_HOLD_CYCLES = quad_port_irq_pkg::DRV_HOLD_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_aen_in,
  input wire logic io_rd_n_in,
  input wire logic io_wr_n_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe_out,
  input wire logic compat_mode_in,
  input wire logic [4:0] compat_base_in,
  input wire logic [3:0] uart_irq_in,
  input wire logic [3:0] uart_txd_in,
  output logic [3:0] uart_cs_out,
  output logic uart_rd_out,
  output logic uart_wr_out,
  output logic irq_line4_out,
  output logic irq_line3_out,
  output logic [3:0] drv_en_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [15:0] addr_s;
  logic aen_s, rd_n_s, wr_n_s, compat_s;
  logic [4:0] base_s;
  logic [3:0] irq_s, txd_s;

  pin_sync #(
    .WIDTH(19),
    .RST_VAL({16'h0000, 3'h7})
  ) u_bus_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in({io_addr_in, io_aen_in, io_rd_n_in, io_wr_n_in}),
    .level_out({addr_s, aen_s, rd_n_s, wr_n_s})
  );

  // Transmit lines reset to idle so no driver turns on when reset releases
  pin_sync #(
    .WIDTH(14),
    .RST_VAL({10'h000, 4'hf})
  ) u_port_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in({compat_mode_in, compat_base_in, uart_irq_in, uart_txd_in}),
    .level_out({compat_s, base_s, irq_s, txd_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic [3:0] decode_port(input logic [15:0] a, input logic compat, input logic [4:0] base);
    logic [3:0] sel;
    sel = 4'h0;
    if (a[15:quad_port_irq_pkg::ADDR_HIGH_LSB] != '0) begin
      sel = 4'h0;
    end else if (compat) begin
      if (a[quad_port_irq_pkg::COMPAT_BASE_MSB:quad_port_irq_pkg::COMPAT_BASE_LSB] == base) begin
        sel = 4'h1 << a[quad_port_irq_pkg::COMPAT_SEL_MSB:quad_port_irq_pkg::COMPAT_SEL_LSB];
      end
    end else begin
      for (int i = 0; i < quad_port_irq_pkg::NUM_PORTS; i++) begin
        // Low three bits are the port's own eight registers
        if (a[15:quad_port_irq_pkg::PORT_SPAN_LSB] ==
            quad_port_irq_pkg::FACTORY_BASE[i][15:quad_port_irq_pkg::PORT_SPAN_LSB]) begin
          sel[i] = 1'b1;
        end
      end
    end
    return sel;
  endfunction

  logic [3:0] port_sel;
  logic rd_act, wr_act, at_status;

  assign port_sel = decode_port(addr_s, compat_s, base_s);
  assign rd_act = !rd_n_s && !aen_s;
  assign wr_act = !wr_n_s && !aen_s;
  assign at_status = addr_s[2:0] == quad_port_irq_pkg::STATUS_OFFSET;

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle state
  quad_port_irq_pkg::bus_state_e bus_state_ff;
  quad_port_irq_pkg::bus_state_e nxt_bus_state;
  logic [3:0] sel_ff;
  logic is_status_ff;
  logic [15:0] addr_ff;

  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      quad_port_irq_pkg::BUS_IDLE: begin
        if (rd_act && (port_sel != 4'h0)) begin
          nxt_bus_state = quad_port_irq_pkg::BUS_READ;
        end else if (wr_act && (port_sel != 4'h0)) begin
          nxt_bus_state = quad_port_irq_pkg::BUS_WRITE;
        end
      end
      quad_port_irq_pkg::BUS_READ: begin
        if (!rd_act) begin
          nxt_bus_state = quad_port_irq_pkg::BUS_IDLE;
        end
      end
      quad_port_irq_pkg::BUS_WRITE: begin
        if (!wr_act) begin
          nxt_bus_state = quad_port_irq_pkg::BUS_IDLE;
        end
      end
      default: begin
        nxt_bus_state = quad_port_irq_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state_ff <= quad_port_irq_pkg::BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // Cycle attributes are frozen at entry so a drifting address cannot move them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_ff <= 4'h0;
      is_status_ff <= 1'b0;
      addr_ff <= 16'h0000;
    end else if (bus_state_ff == quad_port_irq_pkg::BUS_IDLE) begin
      sel_ff <= port_sel;
      is_status_ff <= at_status;
      addr_ff <= addr_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host bus answers
  logic [3:0] uart_cs_ff;
  logic uart_rd_ff, uart_wr_ff, data_oe_ff;
  logic [7:0] data_ff;
  logic in_read, in_write;

  assign in_read = bus_state_ff == quad_port_irq_pkg::BUS_READ;
  assign in_write = bus_state_ff == quad_port_irq_pkg::BUS_WRITE;

  // The status location is ours in both directions; the UART never sees it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      uart_cs_ff <= 4'h0;
      uart_rd_ff <= 1'b0;
      uart_wr_ff <= 1'b0;
    end else begin
      uart_cs_ff <= ((in_read || in_write) && !is_status_ff) ? sel_ff : 4'h0;
      uart_rd_ff <= in_read && !is_status_ff;
      uart_wr_ff <= in_write && !is_status_ff;
    end
  end

  // Status is resampled every cycle of the read, so a late interrupt still shows
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_oe_ff <= 1'b0;
      data_ff <= 8'h00;
    end else begin
      data_oe_ff <= in_read && is_status_ff;
      data_ff <= (in_read && is_status_ff) ?
                 {{quad_port_irq_pkg::STATUS_RSV_W{1'b0}}, irq_s} : 8'h00;
    end
  end

  assign uart_cs_out = uart_cs_ff;
  assign uart_rd_out = uart_rd_ff;
  assign uart_wr_out = uart_wr_ff;
  assign io_data_oe_out = data_oe_ff;
  assign io_data_out = data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Request line routing
  logic irq_line4_ff, irq_line3_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_line4_ff <= 1'b0;
      irq_line3_ff <= 1'b0;
    end else begin
      irq_line4_ff <= |(irq_s & quad_port_irq_pkg::LINE4_PORTS);
      irq_line3_ff <= |(irq_s & quad_port_irq_pkg::LINE3_PORTS);
    end
  end

  assign irq_line4_out = irq_line4_ff;
  assign irq_line3_out = irq_line3_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Automatic line driver enable
  // The hold covers the stop bit; at low baud rates it must be lengthened
  logic [3:0][quad_port_irq_pkg::HOLD_CNT_W-1:0] hold_cnt_ff;
  logic [3:0] drv_en_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_cnt_ff <= '0;
      drv_en_ff <= 4'h0;
    end else begin
      for (int i = 0; i < quad_port_irq_pkg::NUM_PORTS; i++) begin
        if (!txd_s[i]) begin
          hold_cnt_ff[i] <= quad_port_irq_pkg::HOLD_CNT_W'(DRV_HOLD_CYCLES);
          drv_en_ff[i] <= 1'b1;
        end else if (hold_cnt_ff[i] != '0) begin
          hold_cnt_ff[i] <= hold_cnt_ff[i] - 1'b1;
          drv_en_ff[i] <= hold_cnt_ff[i] > quad_port_irq_pkg::HOLD_CNT_W'(1);
        end else begin
          drv_en_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign drv_en_out = drv_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_status_entry;
    bus_state_ff == quad_port_irq_pkg::BUS_IDLE && rd_act && (port_sel != 4'h0) && at_status;
  endsequence
  sequence s_status_drive;
    ##2 (io_data_oe_out && (io_data_out[3:0] == $past(irq_s)) && (uart_cs_out == 4'h0));
  endsequence

  property p_status_any_port;
    s_status_entry |-> s_status_drive;
  endproperty
  a_status_any_port: assert property (p_status_any_port) else $error("status read not answered");
  property p_status_bits;
    io_data_oe_out |-> io_data_out[3:0] == $past(irq_s);
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status bits wrong");
  property p_upper_zero;
    io_data_oe_out |-> io_data_out[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("status upper bits not zero");
  property p_no_uart_on_status;
    (io_data_oe_out || (in_write && is_status_ff)) |-> (uart_cs_out == 4'h0) && !uart_wr_out;
  endproperty
  a_no_uart_on_status: assert property (p_no_uart_on_status) else $error("status access reached UART");
  property p_no_alias;
    ((uart_cs_out != 4'h0) || io_data_oe_out) |-> addr_ff[15:10] == 6'h00;
  endproperty
  a_no_alias: assert property (p_no_alias) else $error("upper address alias decoded");
  property p_factory_base;
    (!compat_s && uart_cs_out[0]) |-> addr_ff[15:3] == 13'h007f;
  endproperty
  a_factory_base: assert property (p_factory_base) else $error("port one not at factory base");
  property p_line_route;
    1'b1 |=> (irq_line4_out == ($past(irq_s[0]) || $past(irq_s[2]))) &&
             (irq_line3_out == ($past(irq_s[1]) || $past(irq_s[3])));
  endproperty
  a_line_route: assert property (p_line_route) else $error("request line routing wrong");
  property p_one_port;
    $onehot0(uart_cs_out);
  endproperty
  a_one_port: assert property (p_one_port) else $error("more than one port selected");
  property p_compat_slot;
    (compat_s && (uart_cs_out != 4'h0)) |-> uart_cs_out == (4'h1 << addr_ff[4:3]);
  endproperty
  a_compat_slot: assert property (p_compat_slot) else $error("compatibility slot wrong");
  property p_drv_on;
    !txd_s[0] |=> drv_en_out[0] [*3];
  endproperty
  a_drv_on: assert property (p_drv_on) else $error("driver not enabled for transmit");
  property p_drv_off;
    (txd_s[0] && hold_cnt_ff[0] == '0) |=> !drv_en_out[0];
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver left enabled");

endmodule

// ### dv/host_bus_model.sv
module host_bus_model (
  input wire logic clk_in,
  output logic [15:0] io_addr_out,
  output logic io_aen_out,
  output logic io_rd_n_out,
  output logic io_wr_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_addr_out = 16'h0000;
    io_aen_out = 1'b0;
    io_rd_n_out = 1'b1;
    io_wr_n_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address settles through the synchroniser before any strobe falls
  task automatic start(input logic [15:0] addr, input logic wr, input logic aen);
    @(negedge clk_in);
    io_addr_out = addr;
    io_aen_out = aen;
    repeat (5) @(negedge clk_in);
    if (wr) begin
      io_wr_n_out = 1'b0;
    end else begin
      io_rd_n_out = 1'b0;
    end
  endtask

  // Strobe stays high long enough for the outputs to drop before the next cycle
  task automatic finish();
    @(negedge clk_in);
    io_rd_n_out = 1'b1;
    io_wr_n_out = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
endmodule

// ### dv/testbench.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned HOLD = 8;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] io_addr;
  logic io_aen, io_rd_n, io_wr_n, io_data_oe, uart_rd, uart_wr, line4, line3;
  logic [7:0] io_data;
  logic compat_mode = 1'b0;
  logic [4:0] compat_base = 5'h00;
  logic [3:0] uart_irq = 4'h0;
  logic [3:0] uart_txd = 4'hf;
  logic [3:0] uart_cs, drv_en;
  logic [15:0] base_tbl [4] = '{16'h03f8, 16'h02f8, 16'h03e8, 16'h02e8};
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2.5 clk_in = ~clk_in;

  host_bus_model host_bus_model_i (.clk_in(clk_in), .io_addr_out(io_addr), .io_aen_out(io_aen),
    .io_rd_n_out(io_rd_n), .io_wr_n_out(io_wr_n));

  quad_port_irq_status_decode #(.DRV_HOLD_CYCLES(HOLD)) quad_port_irq_status_decode_i (
    .clk_in(clk_in), .rst_in(rst_in), .io_addr_in(io_addr), .io_aen_in(io_aen),
    .io_rd_n_in(io_rd_n), .io_wr_n_in(io_wr_n), .io_data_out(io_data), .io_data_oe_out(io_data_oe),
    .compat_mode_in(compat_mode), .compat_base_in(compat_base), .uart_irq_in(uart_irq),
    .uart_txd_in(uart_txd), .uart_cs_out(uart_cs), .uart_rd_out(uart_rd), .uart_wr_out(uart_wr),
    .irq_line4_out(line4), .irq_line3_out(line3), .drv_en_out(drv_en));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] ex(input logic [3:0] cs, input logic [2:0] ctl, input logic [7:0] d);
    return {cs, ctl, d};
  endfunction

  // Outputs settle six edges after the strobe; sample at the eighth
  task automatic bus(input logic [15:0] a, input logic w, input logic aen, input logic [14:0] exp);
    host_bus_model_i.start(a, w, aen);
    repeat (8) @(posedge clk_in);
    #1;
    `CHK({uart_cs, uart_rd, uart_wr, io_data_oe, io_data}, exp)
    host_bus_model_i.finish();
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_status();
    for (int j = 0; j < 4; j++) begin
      for (int k = 0; k < 4; k++) begin
        @(negedge clk_in);
        uart_irq = 4'h1 << k;
        bus(base_tbl[j] + 16'h0007, 1'b0, 1'b0, ex(4'h0, 3'b001, {4'h0, 4'h1 << k}));
      end
    end
    @(negedge clk_in);
    uart_irq = 4'h0;
    $display("test status done");
  endtask

  task automatic test_forward();
    for (int j = 0; j < 4; j++) begin
      bus(base_tbl[j], 1'b0, 1'b0, ex(4'h1 << j, 3'b100, 8'h00));
      bus(base_tbl[j] + 16'h0003, 1'b1, 1'b0, ex(4'h1 << j, 3'b010, 8'h00));
      bus(base_tbl[j] + 16'h0007, 1'b1, 1'b0, ex(4'h0, 3'b000, 8'h00));
    end
    $display("test forward done");
  endtask

  task automatic test_refuse();
    bus(16'h13ff, 1'b0, 1'b0, ex(4'h0, 3'b000, 8'h00));
    bus(16'h83f8, 1'b0, 1'b0, ex(4'h0, 3'b000, 8'h00));
    bus(16'h03f8, 1'b0, 1'b1, ex(4'h0, 3'b000, 8'h00));
    bus(16'h03f0, 1'b0, 1'b0, ex(4'h0, 3'b000, 8'h00));
    $display("test refuse done");
  endtask

  // Mode pins are used live, so they only move between bus cycles
  task automatic test_compat();
    @(negedge clk_in);
    compat_mode = 1'b1;
    compat_base = 5'h17;
    uart_irq = 4'h9;
    for (int j = 0; j < 4; j++) begin
      bus(16'h02e1 + 16'(8 * j), 1'b0, 1'b0, ex(4'h1 << j, 3'b100, 8'h00));
      bus(16'h02e7 + 16'(8 * j), 1'b0, 1'b0, ex(4'h0, 3'b001, 8'h09));
    end
    bus(16'h0300, 1'b0, 1'b0, ex(4'h0, 3'b000, 8'h00));
    bus(16'h06e1, 1'b0, 1'b0, ex(4'h0, 3'b000, 8'h00));
    @(negedge clk_in);
    compat_mode = 1'b0;
    uart_irq = 4'h0;
    $display("test compat done");
  endtask

  task automatic test_lines();
    logic [3:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 4'h1 << k;
      @(negedge clk_in);
      uart_irq = v;
      repeat (7) @(posedge clk_in);
      #1;
      `CHK({line4, line3}, {v[0] | v[2], v[1] | v[3]})
    end
    @(negedge clk_in);
    uart_irq = 4'h0;
    $display("test lines done");
  endtask

  task automatic test_driver();
    for (int j = 0; j < 4; j++) begin
      repeat (2) @(posedge clk_in);
      #1;
      `CHK(drv_en, 4'h0)
      @(negedge clk_in);
      uart_txd[j] = 1'b0;
      repeat (4) @(negedge clk_in);
      uart_txd = 4'hf;
      repeat (3) @(posedge clk_in);
      #1;
      `CHK(drv_en, 4'h1 << j)
      repeat (4) @(posedge clk_in);
      #1;
      `CHK(drv_en, 4'h1 << j)
      repeat (20) @(posedge clk_in);
      #1;
      `CHK(drv_en, 4'h0)
    end
    $display("test driver done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Ceiling sits well above the thousand or so cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    test_status();
    test_forward();
    test_refuse();
    test_compat();
    test_lines();
    test_driver();
    end_of_test();
  end
endmodule
